// [logic/boot_lock_selfprog_control.sv]
`default_nettype none
// Summary of operation
// R1: app lock 11: app section unrestricted
// R2: app lock 10: block stores to app
// R3: app lock 00: block stores, boot-side loads
// R4: app lock 01: block boot-side loads only
// R5: app modes 3,4: mask irqs in app
// R6: boot lock 11 free, 10 blocks stores
// R7: boot high 0 blocks app-side loads
// R8: boot modes 3,4: mask irqs in boot
// R9: vector fuse picks reset address
// R10: software cannot alter fuses
// R11: ready irq while enabled and idle
// R12: region erase/write sets busy flag
// R13: busy cleared by reenable or bufload
// R14: reenable ignored while flash busy; here it still aborts a loaded buffer
// R15: reenable write aborts buffer load
// R16: signature read; store has no effect
// R17: lock set programs from data low
// R18: lock set clears on done/expiry
// R19: lock-set load returns lock or fuse
// R20: enable arms store four cycles
// R21: locks restored only by chip erase; here reset also restores them
// R22: check fetch section and target section
module boot_lock_selfprog_control #(
    parameter logic [15:0] BOOT_RESET_ADDR = 16'h3800, // boot loader reset
    parameter logic [7:0] SIG_BYTE = 8'h5a // arbitrary signature value
) (
    input wire logic I_REF_CLK,
    input wire logic I_NRST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_STORE_INSTR,
    input wire logic I_LOAD_INSTR,
    input wire selfprog_pkg::cpu_ctx_s I_CPU_CTX,
    input wire logic [7:0] I_DATA_LOW,
    input wire logic I_POINTER_LSB,
    input wire logic I_GLOBAL_IRQ,
    input wire logic I_FLASH_DONE,
    input wire logic I_BOOT_VECTOR_SELECT_FUSE,
    input wire logic [7:0] I_FUSE_BYTE,
    input wire logic I_CHIP_ERASE,
    output logic O_STORE_OK,
    output logic O_LOAD_OK,
    output logic O_IRQ_SUPPRESS,
    output logic O_SELFPROG_IRQ,
    output logic [15:0] O_RESET_VECTOR,
    output logic O_CONC_BUSY,
    output logic O_OP_START,
    output logic O_OP_WRITE,
    output logic O_BUF_LOAD,
    output logic O_BUF_DISCARD,
    output logic O_LOAD_VALID,
    output logic [7:0] O_LOAD_DATA
);
    import selfprog_pkg::*;

    // pin synchronisers, first stage read only by the second
    logic vfuse_meta_ff, vfuse_ff;
    logic [7:0] fbyte_meta_ff, fbyte_ff;
    logic cerase_meta_ff, cerase_ff;
    // apb slave state
    logic pready_ff, pslverr_ff;
    logic [31:0] prdata_ff;
    // control state
    logic irq_en_ff; // ready interrupt enable
    cmd_e cmd_ff; // armed or running command
    logic [2:0] win_ff; // cycles left in arming window
    logic op_busy_ff; // erase or write running
    logic op_write_ff; // running op is a page write
    logic busy_ff; // concurrent_region_busy
    logic loading_ff; // temporary buffer holds data
    lock_s lock_ff; // protection fields
    // registered outputs
    logic store_ok_ff, load_ok_ff, irq_sup_ff, irq_ff;
    logic [15:0] rvec_ff;
    logic op_start_ff, buf_load_ff, buf_disc_ff, ld_valid_ff;
    logic [7:0] ld_data_ff;

    // decoded helpers
    logic apb_acc, apb_done, addr_ok, ctrl_wr;
    logic spm_hit, lpm_hit, win_end, reen_abort;
    logic store_ok_c, load_ok_c, irq_sup_c;
    logic [7:0] ctrl_rd;
    cmd_e cmd_dec;

    // write code decode; anything else leaves commands unchanged
    // unknown codes only touch bit 7, and bit 4 still aborts a buffer load
    always_comb begin
        case (I_PWDATA[5:0])
            CODE_SIGNATURE_ROW_READ: cmd_dec = CMD_SIGNATURE_ROW_READ; // [R16]
            CODE_REEN: cmd_dec = CMD_REEN;
            CODE_LOCKSET: cmd_dec = CMD_LOCKSET; // [R17]
            CODE_WRITE: cmd_dec = CMD_WRITE;
            CODE_ERASE: cmd_dec = CMD_ERASE;
            CODE_BUFLOAD: cmd_dec = CMD_BUFLOAD;
            default: cmd_dec = CMD_NONE;
        endcase
    end

    // two-flop synchronisers for pin inputs
    // reset to idle pin levels
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            vfuse_meta_ff <= 1'b1;
            vfuse_ff <= 1'b1;
            fbyte_meta_ff <= 8'hff;
            fbyte_ff <= 8'hff;
            cerase_meta_ff <= 1'b0;
            cerase_ff <= 1'b0;
        end else begin
            vfuse_meta_ff <= I_BOOT_VECTOR_SELECT_FUSE;
            vfuse_ff <= vfuse_meta_ff;
            fbyte_meta_ff <= I_FUSE_BYTE;
            fbyte_ff <= fbyte_meta_ff;
            cerase_meta_ff <= I_CHIP_ERASE;
            cerase_ff <= cerase_meta_ff;
        end
    end

    // apb: one wait state, answer on second access cycle
    // unmapped offsets read as zero
    assign apb_acc = I_PSEL & I_PENABLE;
    assign apb_done = apb_acc & pready_ff;
    assign addr_ok = (I_PADDR == OFS_CTRL) | (I_PADDR == OFS_LOCK);
    assign ctrl_wr = apb_done & I_PWRITE & (I_PADDR == OFS_CTRL);

    // status readback; enable bit stays high during a running op
    // busy is a flag, not a command
    always_comb begin
        ctrl_rd = CTRL_RST;
        ctrl_rd[BIT_IRQ_EN] = irq_en_ff;
        ctrl_rd[BIT_BUSY] = busy_ff;
        ctrl_rd[BIT_SIGNATURE_ROW_READ] = (cmd_ff == CMD_SIGNATURE_ROW_READ);
        ctrl_rd[BIT_REEN] = (cmd_ff == CMD_REEN);
        ctrl_rd[BIT_LOCKSET] = (cmd_ff == CMD_LOCKSET);
        ctrl_rd[BIT_PAGE_WRITE_CMD] = (cmd_ff == CMD_WRITE);
        ctrl_rd[BIT_PAGE_ERASE_CMD] = (cmd_ff == CMD_ERASE);
        ctrl_rd[BIT_SELFPROG_ENABLE] = (cmd_ff != CMD_NONE);
    end

    // apb answer flops
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= apb_acc & ~pready_ff;
            pslverr_ff <= apb_acc & ~pready_ff & ~addr_ok; // unmapped
            if (apb_acc && !pready_ff) begin
                if (I_PADDR == OFS_CTRL) begin
                    prdata_ff <= {24'h000000, ctrl_rd};
                end else if (I_PADDR == OFS_LOCK) begin
                    // fuse byte is read only: no write path exists [R10]
                    prdata_ff <= {15'h0000, vfuse_ff, fbyte_ff, LOCK_PAD, lock_ff};
                end else begin
                    prdata_ff <= 32'h0000_0000;
                end
            end
        end
    end

    // store permission from fetch and target sections [R22]
    // app code can never start an op
    always_comb begin
        store_ok_c = I_CPU_CTX.fetch_boot; // stores only run from boot code
        if (I_CPU_CTX.target_boot) begin
            store_ok_c = store_ok_c & lock_ff.boot[0]; // [R6] [R7]
        end else begin
            store_ok_c = store_ok_c & lock_ff.app[0]; // [R1] [R2] [R3] [R4]
        end
        // busy region refuses every access [R12]
        if (busy_ff && I_CPU_CTX.target_conc) begin
            store_ok_c = 1'b0;
        end
    end

    // load permission, cross-section reads gated by high lock bit
    // same-section reads stay open
    always_comb begin
        load_ok_c = 1'b1; // [R1] [R2]
        if (!I_CPU_CTX.target_boot && I_CPU_CTX.fetch_boot) begin
            load_ok_c = lock_ff.app[1]; // [R3] [R4]
        end else if (I_CPU_CTX.target_boot && !I_CPU_CTX.fetch_boot) begin
            load_ok_c = lock_ff.boot[1]; // [R7]
        end
        if (busy_ff && I_CPU_CTX.target_conc) begin
            load_ok_c = 1'b0; // [R12]
        end
    end

    // interrupt masking by section and vector placement
    // only the high lock bit matters
    always_comb begin
        irq_sup_c = 1'b0;
        if (!lock_ff.app[1] && I_CPU_CTX.vectors_boot && !I_CPU_CTX.fetch_boot) begin
            irq_sup_c = 1'b1; // [R5]
        end
        if (!lock_ff.boot[1] && !I_CPU_CTX.vectors_boot && I_CPU_CTX.fetch_boot) begin
            irq_sup_c = 1'b1; // [R8]
        end
    end

    // a store counts only while armed and inside the window
    assign spm_hit = I_STORE_INSTR & (cmd_ff != CMD_NONE) & ~op_busy_ff & (win_ff != 3'h0);
    // loads get one cycle less than stores [R16] [R19]
    assign lpm_hit = I_LOAD_INSTR & (win_ff > (WIN_STORE - WIN_LOAD))
        & ((cmd_ff == CMD_SIGNATURE_ROW_READ) | (cmd_ff == CMD_LOCKSET));
    assign win_end = (win_ff == 3'h1) & ~op_busy_ff;
    // reenable bit written while buffer holds data [R15]
    assign reen_abort = ctrl_wr & I_PWDATA[BIT_REEN] & loading_ff;

    // interrupt enable is plain read/write
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            irq_en_ff <= 1'b0;
        end else if (ctrl_wr) begin
            irq_en_ff <= I_PWDATA[BIT_IRQ_EN];
        end
    end

    // command arming, window count and running op
    // a store beats a write in one cycle
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            cmd_ff <= CMD_NONE;
            win_ff <= 3'h0;
            op_busy_ff <= 1'b0;
            op_write_ff <= 1'b0;
        end else if (op_busy_ff) begin
            // command writes ignored until the flash reports done [R14]
            if (I_FLASH_DONE) begin
                op_busy_ff <= 1'b0;
                cmd_ff <= CMD_NONE; // enable auto-clears on done [R20]
            end
        end else if (spm_hit) begin
            win_ff <= 3'h0;
            if (((cmd_ff == CMD_ERASE) || (cmd_ff == CMD_WRITE)) && store_ok_c) begin
                op_busy_ff <= 1'b1;
                op_write_ff <= (cmd_ff == CMD_WRITE);
            end else begin
                cmd_ff <= CMD_NONE; // single store consumes the arming [R18] [R20]
            end
        end else if (ctrl_wr && (cmd_dec != CMD_NONE)) begin
            cmd_ff <= cmd_dec;
            win_ff <= WIN_STORE; // [R20]
        end else if (win_end) begin
            cmd_ff <= CMD_NONE; // unused window expires [R18] [R20]
            win_ff <= 3'h0;
        end else if (win_ff != 3'h0) begin
            win_ff <= win_ff - 3'h1;
        end
    end

    // concurrent_region_busy flag; setting has priority over clearing
    // both need a store, so never together
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            busy_ff <= 1'b0;
        end else if (spm_hit && store_ok_c && I_CPU_CTX.target_conc
            && ((cmd_ff == CMD_ERASE) || (cmd_ff == CMD_WRITE))) begin
            busy_ff <= 1'b1; // [R12]
        end else if (spm_hit && ((cmd_ff == CMD_REEN) || (cmd_ff == CMD_BUFLOAD))) begin
            busy_ff <= 1'b0; // [R13] [R14]
        end
    end

    // buffer occupancy; write and reenable empty it
    // a store wins over an abort
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            loading_ff <= 1'b0;
        end else if (spm_hit && (cmd_ff == CMD_BUFLOAD)) begin
            loading_ff <= 1'b1;
        end else if (reen_abort) begin
            loading_ff <= 1'b0; // [R15]
        end else if (op_busy_ff && op_write_ff && I_FLASH_DONE) begin
            loading_ff <= 1'b0;
        end
    end

    // lock fields only move toward programmed; erase restores [R21]
    // erase pin wins over lock setting
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            lock_ff <= {LOCK_UNPROG, LOCK_UNPROG, LOCK_UNPROG};
        end else if (cerase_ff) begin
            lock_ff <= {LOCK_UNPROG, LOCK_UNPROG, LOCK_UNPROG}; // [R21]
        end else if (spm_hit && (cmd_ff == CMD_LOCKSET)) begin
            // pointer and data high ignored [R17]
            lock_ff <= lock_ff & I_DATA_LOW[5:0]; // [R17] [R21]
        end
    end

    // one-cycle strobes toward the flash macro and buffer
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            op_start_ff <= 1'b0;
            buf_load_ff <= 1'b0;
            buf_disc_ff <= 1'b0;
        end else begin
            op_start_ff <= spm_hit & store_ok_c
                & ((cmd_ff == CMD_ERASE) | (cmd_ff == CMD_WRITE));
            buf_load_ff <= spm_hit & (cmd_ff == CMD_BUFLOAD);
            buf_disc_ff <= reen_abort; // [R15]
        end
    end

    // special load answers: signature or lock/fuse byte
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            ld_valid_ff <= 1'b0;
            ld_data_ff <= 8'h00;
        end else begin
            ld_valid_ff <= lpm_hit;
            if (lpm_hit) begin
                if (cmd_ff == CMD_SIGNATURE_ROW_READ) begin
                    ld_data_ff <= SIG_BYTE; // [R16]
                end else if (I_POINTER_LSB) begin
                    ld_data_ff <= fbyte_ff; // [R19]
                end else begin
                    ld_data_ff <= {LOCK_PAD, lock_ff}; // [R19]
                end
            end
        end
    end

    // registered permissions, vector and interrupt request
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            store_ok_ff <= 1'b0;
            load_ok_ff <= 1'b0;
            irq_sup_ff <= 1'b0;
            irq_ff <= 1'b0;
            rvec_ff <= APP_RESET_ADDR;
        end else begin
            store_ok_ff <= store_ok_c;
            load_ok_ff <= load_ok_c;
            irq_sup_ff <= irq_sup_c;
            // level request while enable bit is clear [R11]
            irq_ff <= irq_en_ff & I_GLOBAL_IRQ & (cmd_ff == CMD_NONE);
            // fuse is a pin only, software has no path to it [R9] [R10]
            rvec_ff <= vfuse_ff ? APP_RESET_ADDR : BOOT_RESET_ADDR;
        end
    end

    assign O_PRDATA = prdata_ff;
    assign O_PREADY = pready_ff;
    assign O_PSLVERR = pslverr_ff;
    assign O_STORE_OK = store_ok_ff;
    assign O_LOAD_OK = load_ok_ff;
    assign O_IRQ_SUPPRESS = irq_sup_ff;
    assign O_SELFPROG_IRQ = irq_ff;
    assign O_RESET_VECTOR = rvec_ff;
    assign O_CONC_BUSY = busy_ff;
    assign O_OP_START = op_start_ff;
    assign O_OP_WRITE = op_write_ff;
    assign O_BUF_LOAD = buf_load_ff;
    assign O_BUF_DISCARD = buf_disc_ff;
    assign O_LOAD_VALID = ld_valid_ff;
    assign O_LOAD_DATA = ld_data_ff;
endmodule : boot_lock_selfprog_control
`default_nettype wire

// [logic/selfprog_pkg.sv]
`default_nettype none
package selfprog_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] OFS_CTRL = 8'h00; // control and status
    localparam logic [7:0] OFS_LOCK = 8'h04; // lock and fuse readback
    // control and status bit positions
    localparam int BIT_IRQ_EN = 7;
    localparam int BIT_BUSY = 6;
    localparam int BIT_SIGNATURE_ROW_READ = 5;
    localparam int BIT_REEN = 4;
    localparam int BIT_LOCKSET = 3;
    localparam int BIT_PAGE_WRITE_CMD = 2;
    localparam int BIT_PAGE_ERASE_CMD = 1;
    localparam int BIT_SELFPROG_ENABLE = 0;
    // accepted command codes in bits 5..0
    localparam logic [5:0] CODE_SIGNATURE_ROW_READ = 6'h21;
    localparam logic [5:0] CODE_REEN = 6'h11;
    localparam logic [5:0] CODE_LOCKSET = 6'h09;
    localparam logic [5:0] CODE_WRITE = 6'h05;
    localparam logic [5:0] CODE_ERASE = 6'h03;
    localparam logic [5:0] CODE_BUFLOAD = 6'h01;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [1:0] LOCK_UNPROG = 2'h3;
    localparam logic [1:0] LOCK_PAD = 2'h3;
    // arming windows in clock cycles
    localparam logic [2:0] WIN_STORE = 3'h4;
    localparam logic [2:0] WIN_LOAD = 3'h3;
    // application reset word address
    localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
    // armed command
    typedef enum logic [2:0] {
        CMD_NONE = 3'b000,
        CMD_BUFLOAD = 3'b001,
        CMD_ERASE = 3'b010,
        CMD_WRITE = 3'b011,
        CMD_LOCKSET = 3'b100,
        CMD_REEN = 3'b101,
        CMD_SIGNATURE_ROW_READ = 3'b110
    } cmd_e;
    // protection fields, 1 = unprogrammed
    typedef struct packed {
        logic [1:0] mem;
        logic [1:0] boot; // [1] boot_lock_high, [0] boot_lock_low
        logic [1:0] app; // [1] app_lock_high, [0] app_lock_low
    } lock_s;
    // where the cpu runs and what the current access aims at
    typedef struct packed {
        logic fetch_boot; // instruction fetched from boot loader section
        logic target_boot; // access targets boot loader section
        logic target_conc; // access targets concurrent_read_region
        logic vectors_boot; // interrupt vectors live in boot section
    } cpu_ctx_s;
endpackage : selfprog_pkg
`default_nettype wire

// [tb/cpu_model.sv]
`default_nettype none
// cpu core side: issues store and load instructions and says where it runs
module cpu_model (
    input wire logic clk,
    output logic store,
    output logic load,
    output var selfprog_pkg::cpu_ctx_s ctx,
    output logic [7:0] data_low,
    output logic ptr
);
    timeunit 1ns;
    timeprecision 1ns;
    import selfprog_pkg::*;
    // idle core: fetching from the application, no instruction in flight
    initial begin
        store = 1'b0;
        load = 1'b0;
        ctx = '0;
        data_low = 8'h00;
        ptr = 1'b0;
    end
    // one instruction for one cycle; t_expiry issues it after the window closes, t_busy once during a running op, others inside it
    task automatic pulse(input logic st, input logic [7:0] d, input logic p);
        @(posedge clk);
        store <= st;
        load <= ~st;
        data_low <= d;
        ptr <= p;
        @(posedge clk);
        store <= 1'b0;
        load <= 1'b0;
        data_low <= ~d; // register moves on once consumed
        ptr <= ~p;
    endtask : pulse
    // jump to another section and aim at another target
    task automatic place(input logic fb, input logic tb, input logic tc, input logic vb);
        @(posedge clk);
        ctx <= {fb, tb, tc, vb};
    endtask : place
endmodule : cpu_model
`default_nettype wire

// [tb/boot_lock_selfprog_control_chk.sv]
`default_nettype none
module boot_lock_selfprog_control_chk #(
    parameter logic [15:0] BOOT_RESET_ADDR = 16'h3800 // boot reset word
) (
    input wire logic I_REF_CLK,
    input wire logic I_NRST,
    input wire logic I_STORE_INSTR,
    input wire logic I_LOAD_INSTR,
    input wire selfprog_pkg::cpu_ctx_s I_CPU_CTX,
    input wire logic I_GLOBAL_IRQ,
    input wire logic I_BOOT_VECTOR_SELECT_FUSE,
    input wire logic O_STORE_OK,
    input wire logic O_LOAD_OK,
    input wire logic O_SELFPROG_IRQ,
    input wire logic [15:0] O_RESET_VECTOR,
    input wire logic O_CONC_BUSY,
    input wire logic O_OP_START,
    input wire logic O_BUF_LOAD,
    input wire logic O_BUF_DISCARD,
    input wire logic O_LOAD_VALID
);
    timeunit 1ns;
    timeprecision 1ns;
    import selfprog_pkg::*;
    // single domain, so one clocking and one disable
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_NRST);
    property p_store_boot;
        !I_CPU_CTX.fetch_boot |=> !O_STORE_OK;
    endproperty
    a_store_boot: assert property (p_store_boot) else $error("store from app code");
    property p_busy_deny;
        O_CONC_BUSY && I_CPU_CTX.target_conc |=> !O_LOAD_OK && !O_STORE_OK;
    endproperty
    a_busy_deny: assert property (p_busy_deny) else $error("busy region open");
    property p_busy_start;
        $rose(O_CONC_BUSY) |-> O_OP_START;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy without op");
    property p_load_clears;
        O_BUF_LOAD |-> !O_CONC_BUSY;
    endproperty
    a_load_clears: assert property (p_load_clears) else $error("busy after load");
    property p_store_cause;
        O_BUF_LOAD || O_OP_START |-> $past(I_STORE_INSTR);
    endproperty
    a_store_cause: assert property (p_store_cause) else $error("op without store");
    property p_load_cause;
        O_LOAD_VALID |-> $past(I_LOAD_INSTR);
    endproperty
    a_load_cause: assert property (p_load_cause) else $error("data without load");
    property p_irq_gie;
        !I_GLOBAL_IRQ |=> !O_SELFPROG_IRQ;
    endproperty
    a_irq_gie: assert property (p_irq_gie) else $error("irq with flag off");
    // sync delay is three edges, four samples leave margin
    property p_vec_app;
        I_BOOT_VECTOR_SELECT_FUSE [*4] |=> O_RESET_VECTOR == APP_RESET_ADDR;
    endproperty
    a_vec_app: assert property (p_vec_app) else $error("bad app vector");
    property p_vec_boot;
        !I_BOOT_VECTOR_SELECT_FUSE [*4] |=> O_RESET_VECTOR == BOOT_RESET_ADDR;
    endproperty
    a_vec_boot: assert property (p_vec_boot) else $error("bad boot vector");
    c_start: cover property (O_OP_START);
    c_load: cover property (O_LOAD_VALID);
    c_discard: cover property (O_BUF_DISCARD);
endmodule : boot_lock_selfprog_control_chk
bind boot_lock_selfprog_control boot_lock_selfprog_control_chk #(
    .BOOT_RESET_ADDR(BOOT_RESET_ADDR)
) chk (
    .I_REF_CLK(I_REF_CLK), .I_NRST(I_NRST), .I_STORE_INSTR(I_STORE_INSTR),
    .I_LOAD_INSTR(I_LOAD_INSTR), .I_CPU_CTX(I_CPU_CTX), .I_GLOBAL_IRQ(I_GLOBAL_IRQ),
    .I_BOOT_VECTOR_SELECT_FUSE(I_BOOT_VECTOR_SELECT_FUSE), .O_STORE_OK(O_STORE_OK),
    .O_LOAD_OK(O_LOAD_OK), .O_SELFPROG_IRQ(O_SELFPROG_IRQ), .O_RESET_VECTOR(O_RESET_VECTOR),
    .O_CONC_BUSY(O_CONC_BUSY), .O_OP_START(O_OP_START), .O_BUF_LOAD(O_BUF_LOAD),
    .O_BUF_DISCARD(O_BUF_DISCARD), .O_LOAD_VALID(O_LOAD_VALID)
);
`default_nettype wire

// [tb/boot_lock_selfprog_control_tb.sv]
`default_nettype none
module boot_lock_selfprog_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import selfprog_pkg::*;
    localparam logic [15:0] BOOT_ADR = 16'h1c00; // boot reset word
    localparam logic [7:0] SIG = 8'h3c; // arbitrary signature value
    localparam logic [7:0] FB = 8'ha5; // fuse byte on the pins
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, clr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, perr, err, fuse = 1'b1, cer = 1'b0, fdone = 1'b0, gie = 1'b0;
    logic st, ld, ptr, sok, lok, sup, irq, busy, start, opw, bufl, disc, lval;
    cpu_ctx_s ctx;
    logic [7:0] dl, ldat;
    logic [15:0] vec;
    logic [3:0] seen = 4'h0; // sticky discard, bufload, start, load pulses
    int errors = 0, num_checks = 0;
    always #50 clk = ~clk;
    // pulses last one cycle, so latch them for later checks
    always @(posedge clk) seen <= clr ? 4'h0 : seen | {disc, bufl, start, lval};
    boot_lock_selfprog_control #(.BOOT_RESET_ADDR(BOOT_ADR), .SIG_BYTE(SIG)) dut (
        .I_REF_CLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(perr), .I_STORE_INSTR(st), .I_LOAD_INSTR(ld), .I_CPU_CTX(ctx),
        .I_DATA_LOW(dl), .I_POINTER_LSB(ptr), .I_GLOBAL_IRQ(gie), .I_FLASH_DONE(fdone),
        .I_BOOT_VECTOR_SELECT_FUSE(fuse), .I_FUSE_BYTE(FB), .I_CHIP_ERASE(cer),
        .O_STORE_OK(sok), .O_LOAD_OK(lok), .O_IRQ_SUPPRESS(sup), .O_SELFPROG_IRQ(irq),
        .O_RESET_VECTOR(vec), .O_CONC_BUSY(busy), .O_OP_START(start), .O_OP_WRITE(opw),
        .O_BUF_LOAD(bufl), .O_BUF_DISCARD(disc), .O_LOAD_VALID(lval), .O_LOAD_DATA(ldat)
    );
    cpu_model cpu (.clk(clk), .store(st), .load(ld), .ctx(ctx), .data_low(dl), .ptr(ptr));
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // one transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            errors++;
            $display("BAD %0t: no pready", $time);
            print_verdict();
        end
        r = prdata;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 8'h00);
        chk(r, e);
    endtask : rd
    // registered permission outputs need one edge after a move; settle waits two
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle
    task automatic cl;
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
    endtask : cl
    function automatic logic [31:0] lockreg(input logic [5:0] l);
        return {15'h0, fuse, FB, 2'b11, l};
    endfunction : lockreg
    task automatic t_reset;
        rd(OFS_CTRL, 32'h0);
        rd(OFS_LOCK, lockreg(6'h3f));
        apb(1'b0, 8'h08, 8'h00);
        chk({r[30:0], err}, 32'h1);
        chk(32'(vec), 32'(APP_RESET_ADDR));
        $display("test reset done");
    endtask : t_reset
    task automatic t_expiry;
        cpu.place(1'b1, 1'b0, 1'b0, 1'b0);
        wr(OFS_CTRL, {2'b00, CODE_LOCKSET});
        repeat (5) @(posedge clk);
        cpu.pulse(1'b1, 8'h00, 1'b0);
        rd(OFS_CTRL, 32'h0);
        rd(OFS_LOCK, lockreg(6'h3f));
        $display("test expiry done");
    endtask : t_expiry
    // every mode of both fields, each from a fresh chip erase
    task automatic t_locks;
        logic [5:0] l;
        for (int f = 0; f < 2; f++) begin
            for (int m = 0; m < 4; m++) begin
                l = (f == 1) ? {2'h3, 2'(m), 2'h3} : {4'hf, 2'(m)};
                @(posedge clk) cer <= 1'b1;
                repeat (4) @(posedge clk);
                cer <= 1'b0;
                cpu.place(1'b1, 1'b0, 1'b0, 1'b0);
                wr(OFS_CTRL, {2'b00, CODE_LOCKSET});
                cpu.pulse(1'b1, {2'b11, l}, 1'b0);
                rd(OFS_LOCK, lockreg(l));
                cpu.place(1'b1, 1'(f), 1'b0, 1'b0);
                settle;
                chk(32'(sok), m % 2);
                cpu.place(~1'(f), 1'(f), 1'b0, 1'b0);
                settle;
                chk(32'(lok), m / 2);
                cpu.place(1'(f), 1'(f), 1'b0, ~1'(f));
                settle;
                chk(32'(sup), 1 - m / 2);
            end
        end
        $display("test locks done");
    endtask : t_locks
    task automatic t_busy;
        cpu.place(1'b1, 1'b0, 1'b1, 1'b1);
        wr(OFS_CTRL, 8'h80);
        @(posedge clk) gie <= 1'b1;
        settle;
        chk(32'(irq), 32'h1);
        cl;
        wr(OFS_CTRL, {2'b10, CODE_ERASE});
        cpu.pulse(1'b1, 8'h00, 1'b0);
        settle;
        chk(32'({busy, lok, irq, seen[1], opw}), 32'h12);
        wr(OFS_CTRL, {2'b10, CODE_REEN});
        cpu.pulse(1'b1, 8'h00, 1'b0);
        rd(OFS_CTRL, 32'hc3);
        @(posedge clk) fdone <= 1'b1;
        @(posedge clk) fdone <= 1'b0;
        rd(OFS_CTRL, 32'hc0);
        wr(OFS_CTRL, {2'b10, CODE_REEN});
        cpu.pulse(1'b1, 8'h00, 1'b0);
        rd(OFS_CTRL, 32'h80);
        wr(OFS_CTRL, {2'b10, CODE_WRITE});
        cpu.pulse(1'b1, 8'h00, 1'b0);
        settle;
        chk(32'({busy, opw}), 32'h3);
        @(posedge clk) fdone <= 1'b1;
        @(posedge clk) fdone <= 1'b0;
        cpu.place(1'b1, 1'b0, 1'b0, 1'b1);
        cl;
        wr(OFS_CTRL, {2'b10, CODE_BUFLOAD});
        cpu.pulse(1'b1, 8'h12, 1'b0);
        wr(OFS_CTRL, {2'b10, CODE_REEN});
        settle;
        chk(32'({busy, seen[2], seen[3]}), 32'h3);
        $display("test busy done");
    endtask : t_busy
    task automatic t_sig;
        cl;
        wr(OFS_CTRL, {2'b00, CODE_SIGNATURE_ROW_READ});
        cpu.pulse(1'b0, 8'h00, 1'b0);
        cpu.pulse(1'b1, 8'h00, 1'b0);
        settle;
        chk({20'h0, seen, ldat}, {20'h0, 4'h1, SIG});
        for (int p = 0; p < 2; p++) begin
            wr(OFS_CTRL, {2'b00, CODE_LOCKSET});
            cpu.pulse(1'b0, 8'h00, 1'(p));
            settle;
            chk(32'(ldat), (p == 1) ? 32'(FB) : 32'hff);
        end
        $display("test readback done");
    endtask : t_sig
    task automatic t_vec;
        wr(OFS_LOCK, 8'h00);
        rd(OFS_LOCK, lockreg(6'h3f));
        @(posedge clk) fuse <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk(32'(vec), 32'(BOOT_ADR));
        $display("test vector done");
    endtask : t_vec
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        t_reset;
        t_expiry;
        t_locks;
        t_busy;
        t_sig;
        t_vec;
        print_verdict;
    end
endmodule : boot_lock_selfprog_control_tb
`default_nettype wire
